// >>> rtl/ebt_pkg.sv
package ebt_pkg;
  typedef logic [31:0] ebt_word_t;
  typedef logic [7:0] ebt_byte_t;
  // Register indices, byte address is four times the index
  localparam logic [7:0] ASYNC_STATUS_IDX = 8'h22;
  localparam logic [7:0] T2_CONTROL_IDX = 8'h25;
  localparam logic [7:0] T0_CONTROL_IDX = 8'h33;
  localparam logic [7:0] T0_COUNT_IDX = 8'h10;
  localparam logic [7:0] T0_COMPARE_IDX = 8'h11;
  localparam logic [7:0] T2_COUNT_IDX = 8'h12;
  localparam logic [7:0] T2_COMPARE_IDX = 8'h13;
  localparam logic [7:0] FLAGS_IDX = 8'h14;
  localparam logic [7:0] MASK_IDX = 8'h15;
  // Control register fields
  localparam int FORCE_BIT = 7;
  localparam int PWM_BIT = 6;
  localparam int COM_HI = 5;
  localparam int COM_LO = 4;
  localparam int CTC_BIT = 3;
  localparam int CS_HI = 2;
  localparam int CS_LO = 0;
  // Async status fields
  localparam int ASYNC_BIT = 3;
  localparam int UB_COUNT = 2;
  localparam int UB_COMPARE = 1;
  localparam int UB_CONTROL = 0;
  // Flag and mask fields
  localparam int T0_OVF_BIT = 0;
  localparam int T0_CMP_BIT = 1;
  localparam int T2_OVF_BIT = 2;
  localparam int T2_CMP_BIT = 3;
  // Clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_C2 = 3'h2;
  localparam logic [2:0] CS_C3 = 3'h3;
  localparam logic [2:0] CS_C4 = 3'h4;
  localparam logic [2:0] CS_C5 = 3'h5;
  localparam logic [2:0] CS_C6 = 3'h6;
  localparam logic [2:0] CS_C7 = 3'h7;
  // Prescale divide as a power of two
  localparam logic [3:0] SH_DIV8 = 4'h3;
  localparam logic [3:0] SH_DIV32 = 4'h5;
  localparam logic [3:0] SH_DIV64 = 4'h6;
  localparam logic [3:0] SH_DIV128 = 4'h7;
  localparam logic [3:0] SH_DIV256 = 4'h8;
  localparam logic [3:0] SH_DIV1024 = 4'ha;
  // Compare output modes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam ebt_byte_t CNT_TOP = 8'hff;
  localparam ebt_byte_t CNT_BOTTOM = 8'h00;
  localparam ebt_byte_t CNT_TURN = 8'hfe;
  localparam ebt_byte_t CNT_ONE = 8'h01;
  // Crystal edges before an async write lands
  localparam logic [1:0] XTAL_EDGES = 2'h2;
endpackage : ebt_pkg

// >>> rtl/ebt_chan_if.sv
`timescale 1ns/100ps
interface ebt_chan_if;
  logic tick;
  logic [7:0] ctrl;
  logic force_cmp;
  logic cnt_wr;
  logic [7:0] cnt_wdata;
  logic ocr_wr;
  logic [7:0] ocr_wdata;
  logic [7:0] cnt;
  logic [7:0] ocr_rd;
  logic out;
  logic out_on;
  logic match_ev;
  logic ovf_ev;
  modport ctl (
    output tick, ctrl, force_cmp, cnt_wr, cnt_wdata, ocr_wr, ocr_wdata,
    input cnt, ocr_rd, out, out_on, match_ev, ovf_ev
  );
  modport core (
    input tick, ctrl, force_cmp, cnt_wr, cnt_wdata, ocr_wr, ocr_wdata,
    output cnt, ocr_rd, out, out_on, match_ev, ovf_ev
  );
endinterface : ebt_chan_if

// >>> rtl/ebt_chan.sv
`timescale 1ns/100ps
module ebt_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control side
  ebt_chan_if.core ch
);
  import ebt_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] ocr;
    logic [7:0] hold;
    logic down;
    logic out;
    logic on;
    logic block;
  } ebt_chan_st_t;

  ebt_chan_st_t q;
  ebt_chan_st_t nxt_q;
  logic pwm;
  logic ctc;
  logic [1:0] com;
  logic hit;

  function automatic logic ebt_com_act(input logic [1:0] mode,
                                       input logic cur);
    unique case (mode)
      COM_TOGGLE: return ~cur;
      COM_CLEAR: return 1'b0;
      COM_SET: return 1'b1;
      default: return cur;
    endcase
  endfunction : ebt_com_act

  assign pwm = ch.ctrl[PWM_BIT];
  assign ctc = ch.ctrl[CTC_BIT];
  assign com = ch.ctrl[COM_HI:COM_LO];
  assign hit = (q.cnt == q.ocr);

  always_comb
  begin
    nxt_q = q;
    ch.match_ev = 1'b0;
    ch.ovf_ev = 1'b0;
    // PWM modes 0x leave the pin unconnected
    nxt_q.on = pwm ? com[1] : (com != COM_OFF);
    if (ch.ocr_wr)
    begin
      nxt_q.hold = ch.ocr_wdata;
      if (!pwm)
        nxt_q.ocr = ch.ocr_wdata;
    end
    if (ch.cnt_wr)
    begin
      nxt_q.cnt = ch.cnt_wdata;
      nxt_q.block = 1'b1;
    end
    else if (ch.tick)
    begin
      nxt_q.block = 1'b0;
      ch.match_ev = hit && !q.block;
      if (!pwm)
      begin
        ch.ovf_ev = (q.cnt == CNT_TOP);
        nxt_q.cnt = q.cnt + 8'h01;
        if (ch.match_ev && ctc)
          nxt_q.cnt = CNT_BOTTOM;
        if (ch.match_ev)
          nxt_q.out = ebt_com_act(com, q.out);
      end
      else if (!ctc)
      begin
        ch.ovf_ev = (q.cnt == CNT_BOTTOM);
        if (!q.down)
        begin
          nxt_q.cnt = q.cnt + 8'h01;
          if (q.cnt == CNT_TOP)
          begin
            nxt_q.down = 1'b1;
            nxt_q.cnt = CNT_TURN;
          end
        end
        else
        begin
          nxt_q.cnt = q.cnt - 8'h01;
          if (q.cnt == CNT_BOTTOM)
          begin
            nxt_q.down = 1'b0;
            nxt_q.cnt = CNT_ONE;
          end
        end
        if (q.cnt == CNT_TOP)
          nxt_q.ocr = q.hold;
        if (ch.match_ev && com[1])
        begin
          if (q.ocr == CNT_BOTTOM || q.ocr == CNT_TOP)
            nxt_q.out = (q.ocr == CNT_TOP) ^ com[0];
          else
            nxt_q.out = q.down ^ com[0];
        end
      end
      else
      begin
        ch.ovf_ev = (q.cnt == CNT_TOP);
        nxt_q.cnt = q.cnt + 8'h01;
        if (q.cnt == CNT_TOP)
          nxt_q.ocr = q.hold;
        if (com[1])
        begin
          if (ch.match_ev)
            nxt_q.out = com[0];
          if (ch.ovf_ev)
            nxt_q.out = ~com[0];
        end
      end
    end
    if (ch.force_cmp && !pwm)
      nxt_q.out = ebt_com_act(com, nxt_q.out);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= nxt_q;
  end

  assign ch.cnt = q.cnt;
  assign ch.ocr_rd = q.hold;
  assign ch.out = q.out;
  assign ch.out_on = q.on;
endmodule : ebt_chan

// >>> rtl/ebt_top.sv
// The APB slave port was decided locally.
`timescale 1ns/100ps
module ebt_top #(
  parameter int APB_AW = 12,
  parameter int PRE_W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire ebt_pkg::ebt_word_t pwdata,
  output ebt_pkg::ebt_word_t prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic external_count_pin,
  input wire logic crystal_clock_pin,
  output logic timer_zero_compare_out,
  output logic timer_zero_compare_out_active,
  output logic timer_two_compare_out,
  output logic timer_two_compare_out_active,
  output logic crystal_pins_claimed,
  // Interrupt requests
  input wire logic global_int_enable,
  output logic timer_zero_overflow_irq,
  output logic timer_zero_match_irq,
  output logic timer_two_overflow_irq,
  output logic timer_two_match_irq
);
  import ebt_pkg::*;

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (APB_AW < 10)
    $error("APB address too narrow for the register map");
  if (PRE_W < 10)
    $error("Prescaler too narrow for divide by 1024");

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] t0_ctrl;
    logic [7:0] t2_ctrl_sw;
    logic [7:0] t2_ctrl_act;
    logic async_sel;
    logic [2:0] busy;
    logic [2:0][1:0] xedges;
    logic [7:0] tmp_cnt;
    logic [7:0] tmp_ocr;
    logic [3:0] flags;
    logic [3:0] mask;
    logic [3:0] irq;
    logic [PRE_W-1:0] pre0;
    logic [PRE_W-1:0] pre2;
    logic es1;
    logic es2;
    logic es3;
    logic xs1;
    logic xs2;
    logic xs3;
    logic claimed;
    ebt_word_t rdata;
    logic ready;
    logic err;
  } ebt_top_st_t;

  ebt_top_st_t q;
  ebt_top_st_t nxt_q;

  ebt_chan_if ch0 ();
  ebt_chan_if ch2 ();

  logic [7:0] idx;
  logic setup;
  logic wr;
  logic mapped;
  logic wr_t0ctl;
  logic wr_t0cnt;
  logic wr_t0ocr;
  logic wr_t2ctl;
  logic wr_t2cnt;
  logic wr_t2ocr;
  logic wr_async;
  logic wr_flags;
  logic wr_mask;
  logic ext_rise;
  logic ext_fall;
  logic xrise;
  logic src2;
  logic tick0;
  logic tick2;
  logic [2:0] apply;
  logic [2:0] async_wr;
  logic [3:0] set_flags;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic pre_hit(input logic [PRE_W-1:0] pre,
                                   input logic [3:0] sh);
    logic [PRE_W-1:0] m;
    m = ~({PRE_W{1'b1}} << sh);
    return (pre & m) == m;
  endfunction : pre_hit

  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] b);
    return a == b;
  endfunction : reg_hit

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign idx = 8'(paddr[APB_AW-1:2]);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && q.ready;
  assign mapped = reg_hit(idx, ASYNC_STATUS_IDX) ||
                  reg_hit(idx, T0_CONTROL_IDX) ||
                  reg_hit(idx, T2_CONTROL_IDX) ||
                  reg_hit(idx, T0_COUNT_IDX) ||
                  reg_hit(idx, T0_COMPARE_IDX) ||
                  reg_hit(idx, T2_COUNT_IDX) ||
                  reg_hit(idx, T2_COMPARE_IDX) ||
                  reg_hit(idx, FLAGS_IDX) ||
                  reg_hit(idx, MASK_IDX);
  assign wr_t0ctl = wr && reg_hit(idx, T0_CONTROL_IDX);
  assign wr_t0cnt = wr && reg_hit(idx, T0_COUNT_IDX);
  assign wr_t0ocr = wr && reg_hit(idx, T0_COMPARE_IDX);
  assign wr_t2ctl = wr && reg_hit(idx, T2_CONTROL_IDX);
  assign wr_t2cnt = wr && reg_hit(idx, T2_COUNT_IDX);
  assign wr_t2ocr = wr && reg_hit(idx, T2_COMPARE_IDX);
  assign wr_async = wr && reg_hit(idx, ASYNC_STATUS_IDX);
  assign wr_flags = wr && reg_hit(idx, FLAGS_IDX);
  assign wr_mask = wr && reg_hit(idx, MASK_IDX);

  // ---------------------------------------------------------------
  // Clock sources
  // ---------------------------------------------------------------
  // edges seen after sampling
  assign ext_rise = q.es2 && !q.es3;
  assign ext_fall = !q.es2 && q.es3;
  assign xrise = q.xs2 && !q.xs3;
  assign src2 = q.async_sel ? xrise : 1'b1;

  always_comb
  begin
    unique case (q.t0_ctrl[CS_HI:CS_LO])
      CS_STOP: tick0 = 1'b0;
      CS_DIRECT: tick0 = 1'b1;
      CS_C2: tick0 = pre_hit(q.pre0, SH_DIV8);
      CS_C3: tick0 = pre_hit(q.pre0, SH_DIV64);
      CS_C4: tick0 = pre_hit(q.pre0, SH_DIV256);
      CS_C5: tick0 = pre_hit(q.pre0, SH_DIV1024);
      CS_C6: tick0 = ext_fall;
      CS_C7: tick0 = ext_rise;
    endcase
  end

  always_comb
  begin
    unique case (q.t2_ctrl_act[CS_HI:CS_LO])
      CS_STOP: tick2 = 1'b0;
      CS_DIRECT: tick2 = src2;
      CS_C2: tick2 = src2 && pre_hit(q.pre2, SH_DIV8);
      CS_C3: tick2 = src2 && pre_hit(q.pre2, SH_DIV32);
      CS_C4: tick2 = src2 && pre_hit(q.pre2, SH_DIV64);
      CS_C5: tick2 = src2 && pre_hit(q.pre2, SH_DIV128);
      CS_C6: tick2 = src2 && pre_hit(q.pre2, SH_DIV256);
      CS_C7: tick2 = src2 && pre_hit(q.pre2, SH_DIV1024);
    endcase
  end

  // ---------------------------------------------------------------
  // Async write transfer
  // ---------------------------------------------------------------
  assign async_wr[UB_COUNT] = wr_t2cnt && q.async_sel;
  assign async_wr[UB_COMPARE] = wr_t2ocr && q.async_sel;
  assign async_wr[UB_CONTROL] = wr_t2ctl && q.async_sel;

  for (genvar i = 0; i < 3; i++)
  begin : g_apply
    assign apply[i] = xrise && q.busy[i] &&
                      (q.xedges[i] == XTAL_EDGES - 2'h1);
  end

  // ---------------------------------------------------------------
  // Channel hookup
  // ---------------------------------------------------------------
  assign ch0.tick = tick0;
  assign ch0.ctrl = q.t0_ctrl;
  assign ch0.force_cmp = wr_t0ctl && pwdata[FORCE_BIT];
  assign ch0.cnt_wr = wr_t0cnt;
  assign ch0.cnt_wdata = pwdata[7:0];
  assign ch0.ocr_wr = wr_t0ocr;
  assign ch0.ocr_wdata = pwdata[7:0];

  assign ch2.tick = tick2;
  assign ch2.ctrl = q.t2_ctrl_act;
  assign ch2.force_cmp = wr_t2ctl && pwdata[FORCE_BIT] && !q.async_sel;
  assign ch2.cnt_wr = q.async_sel ? apply[UB_COUNT] : wr_t2cnt;
  assign ch2.cnt_wdata = q.async_sel ? q.tmp_cnt : pwdata[7:0];
  assign ch2.ocr_wr = q.async_sel ? apply[UB_COMPARE] : wr_t2ocr;
  assign ch2.ocr_wdata = q.async_sel ? q.tmp_ocr : pwdata[7:0];

  ebt_chan u_chan0 (
    .clk(clk),
    .reset_n(reset_n),
    .ch(ch0.core)
  );

  ebt_chan u_chan2 (
    .clk(clk),
    .reset_n(reset_n),
    .ch(ch2.core)
  );

  assign set_flags[T0_OVF_BIT] = ch0.ovf_ev;
  assign set_flags[T0_CMP_BIT] = ch0.match_ev;
  assign set_flags[T2_OVF_BIT] = ch2.ovf_ev;
  assign set_flags[T2_CMP_BIT] = ch2.match_ev;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_q = q;
    nxt_q.es1 = external_count_pin;
    nxt_q.es2 = q.es1;
    nxt_q.es3 = q.es2;
    nxt_q.xs1 = crystal_clock_pin;
    nxt_q.xs2 = q.xs1;
    nxt_q.xs3 = q.xs2;
    nxt_q.pre0 = q.pre0 + PRE_W'(1);
    if (src2)
      nxt_q.pre2 = q.pre2 + PRE_W'(1);
    nxt_q.ready = 1'b1;
    nxt_q.claimed = q.async_sel;
    if (wr_t0ctl)
      nxt_q.t0_ctrl = pwdata[7:0] & ~(8'h01 << FORCE_BIT);
    if (wr_t2ctl)
    begin
      nxt_q.t2_ctrl_sw = pwdata[7:0] & ~(8'h01 << FORCE_BIT);
      if (!q.async_sel)
        nxt_q.t2_ctrl_act = pwdata[7:0] & ~(8'h01 << FORCE_BIT);
    end
    if (apply[UB_CONTROL] && q.async_sel)
      nxt_q.t2_ctrl_act = q.t2_ctrl_sw;
    if (wr_async)
      nxt_q.async_sel = pwdata[ASYNC_BIT];
    if (wr_t2cnt)
      nxt_q.tmp_cnt = pwdata[7:0];
    if (wr_t2ocr)
      nxt_q.tmp_ocr = pwdata[7:0];
    for (int i = 0; i < 3; i++)
    begin
      if (apply[i])
        nxt_q.busy[i] = 1'b0;
      else if (xrise && q.busy[i])
        nxt_q.xedges[i] = q.xedges[i] + 2'h1;
      if (async_wr[i])
      begin
        nxt_q.busy[i] = 1'b1;
        nxt_q.xedges[i] = 2'h0;
      end
    end
    if (wr_mask)
      nxt_q.mask = pwdata[3:0];
    // Write one clears, a new event wins
    nxt_q.flags = (q.flags & ~(wr_flags ? pwdata[3:0] : 4'h0)) | set_flags;
    nxt_q.irq = q.flags & q.mask & {4{global_int_enable}};
    // Read data is captured in the setup cycle
    if (setup)
    begin
      nxt_q.err = !mapped;
      nxt_q.rdata = '0;
      unique case (1'b1)
        reg_hit(idx, ASYNC_STATUS_IDX):
          nxt_q.rdata = {28'h0, q.async_sel, q.busy};
        reg_hit(idx, T0_CONTROL_IDX):
          nxt_q.rdata = {24'h0, q.t0_ctrl};
        reg_hit(idx, T2_CONTROL_IDX):
          nxt_q.rdata = {24'h0, q.t2_ctrl_sw};
        reg_hit(idx, T0_COUNT_IDX):
          nxt_q.rdata = {24'h0, ch0.cnt};
        reg_hit(idx, T0_COMPARE_IDX):
          nxt_q.rdata = {24'h0, ch0.ocr_rd};
        reg_hit(idx, T2_COUNT_IDX):
          nxt_q.rdata = {24'h0, ch2.cnt};
        reg_hit(idx, T2_COMPARE_IDX):
          nxt_q.rdata = {24'h0, q.async_sel ? q.tmp_ocr : ch2.ocr_rd};
        reg_hit(idx, FLAGS_IDX):
          nxt_q.rdata = {28'h0, q.flags};
        reg_hit(idx, MASK_IDX):
          nxt_q.rdata = {28'h0, q.mask};
        default:
          nxt_q.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= nxt_q;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.err;
  assign timer_zero_compare_out = ch0.out;
  assign timer_zero_compare_out_active = ch0.out_on;
  assign timer_two_compare_out = ch2.out;
  assign timer_two_compare_out_active = ch2.out_on;
  assign crystal_pins_claimed = q.claimed;
  assign timer_zero_overflow_irq = q.irq[T0_OVF_BIT];
  assign timer_zero_match_irq = q.irq[T0_CMP_BIT];
  assign timer_two_overflow_irq = q.irq[T2_OVF_BIT];
  assign timer_two_match_irq = q.irq[T2_CMP_BIT];
endmodule : ebt_top

// >>> verif/ebt_top_sva.sv
`timescale 1ns/100ps
module ebt_top_sva #(
  parameter int APB_AW = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire ebt_pkg::ebt_word_t pwdata,
  input wire ebt_pkg::ebt_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and requests
  input wire logic timer_zero_compare_out_active,
  input wire logic crystal_pins_claimed,
  input wire logic global_int_enable,
  input wire logic timer_zero_overflow_irq,
  input wire logic timer_zero_match_irq,
  input wire logic timer_two_overflow_irq,
  input wire logic timer_two_match_irq
);
  import ebt_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic wr, rd;
  logic [7:0] idx;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  assign idx = paddr[9:2];
  // --------
  // Checks
  // --------
  AST_STATUS_UPPER: assert property (
    rd && idx == ASYNC_STATUS_IDX |-> prdata[31:4] == 28'h0)
    else $error("status upper bits set");
  AST_READ_UPPER: assert property (
    rd |-> prdata[31:8] == 24'h0) else $error("read upper bits set");
  AST_CLAIM: assert property (
    wr && idx == ASYNC_STATUS_IDX
    |-> ##2 crystal_pins_claimed == $past(pwdata[ASYNC_BIT], 2))
    else $error("pin claim does not follow async bit");
  AST_OVF_GIE: assert property (
    !$past(global_int_enable)
    |-> !timer_zero_overflow_irq && !timer_two_overflow_irq)
    else $error("overflow request without global enable");
  AST_MATCH_GIE: assert property (
    !$past(global_int_enable)
    |-> !(timer_zero_match_irq || timer_two_match_irq))
    else $error("match request without global enable");
  AST_MASK: assert property (
    wr && idx == MASK_IDX && pwdata[3:0] == 4'h0
    |-> ##2 !timer_zero_match_irq && !timer_two_match_irq)
    else $error("request while masked");
  AST_OUT_OFF: assert property (
    wr && idx == T0_CONTROL_IDX && pwdata[COM_HI:COM_LO] == COM_OFF
    |-> ##2 !timer_zero_compare_out_active)
    else $error("pin driven with mode off");
  AST_OUT_ON: assert property (
    wr && idx == T0_CONTROL_IDX && pwdata[PWM_BIT] && pwdata[COM_HI]
    |-> ##2 timer_zero_compare_out_active)
    else $error("pin not driven in pwm mode");
  COV_MATCH: cover property ($rose(timer_zero_match_irq));
  COV_CLAIM: cover property ($rose(crystal_pins_claimed));
  COV_ERR: cover property (rd && pslverr);
endmodule : ebt_top_sva

bind ebt_top ebt_top_sva #(.APB_AW(APB_AW)) u_ebt_top_sva (
  .clk(clk),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .timer_zero_compare_out_active(timer_zero_compare_out_active),
  .crystal_pins_claimed(crystal_pins_claimed),
  .global_int_enable(global_int_enable),
  .timer_zero_overflow_irq(timer_zero_overflow_irq),
  .timer_zero_match_irq(timer_zero_match_irq),
  .timer_two_overflow_irq(timer_two_overflow_irq),
  .timer_two_match_irq(timer_two_match_irq)
);

// >>> verif/test_eight_bit_timer_pwm.sv
`timescale 1ns/100ps
module test_eight_bit_timer_pwm;
  import ebt_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ext_pin = 1'b0, xtal_pin = 1'b0, gie = 1'b0;
  logic [11:0] paddr = 12'h000;
  ebt_word_t pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, re, out0, act0, act2, claim, ov0, ma0, ov2, ma2;
  int xdiv = 0;
  logic [31:0] seed = 32'h0000005a;
  int n_fail = 0, checks = 0, k;
  ebt_byte_t b;
  int d0 [6] = '{0, 1, 8, 64, 256, 1024};
  int d2 [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  ebt_byte_t pm [7] = '{8'h61, 8'h71, 8'h69, 8'h79, 8'h69, 8'h61, 8'h71};
  ebt_byte_t pc [7] = '{8'h40, 8'h40, 8'h40, 8'h40, 8'hff, 8'h00, 8'hff};
  int ph [7] = '{256, 764, 258, 762, 1020, 0, 0};

  ebt_top u_ebt_top (
    .clk(clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .external_count_pin(ext_pin),
    .crystal_clock_pin(xtal_pin),
    .timer_zero_compare_out(out0),
    .timer_zero_compare_out_active(act0),
    .timer_two_compare_out(),
    .timer_two_compare_out_active(act2),
    .crystal_pins_claimed(claim),
    .global_int_enable(gie),
    .timer_zero_overflow_irq(ov0),
    .timer_zero_match_irq(ma0),
    .timer_two_overflow_irq(ov2),
    .timer_two_match_irq(ma2)
  );

  always #25 clk = ~clk;
  // Crystal pin toggles every 11 clocks, launched off the rising edge
  always @(posedge clk)
  begin
    xdiv <= (xdiv == 10) ? 0 : xdiv + 1;
    if (xdiv == 10)
      xtal_pin <= ~xtal_pin;
  end

  function automatic ebt_byte_t rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic apb(input logic w, input logic [7:0] a, input ebt_byte_t d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string n, input ebt_word_t x, input ebt_word_t g);
    checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic chkr(input string n, input int lo, input int hi,
    input ebt_word_t g);
    logic ok;
    ok = 1'b0;
    checks++;
    if ($signed(g) >= lo && $signed(g) <= hi)
      ok = 1'b1;
    if (!ok)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %h", n, lo, hi, g);
    end
  endtask : chkr

  // Count over a window that holds about four prescaled ticks, or 40 ticks when undivided
  task automatic tdiv(input logic [7:0] c, input logic [7:0] n,
    input int code, input int d);
    int w, e;
    w = (d == 1) ? 40 : (d == 0) ? 64 : 4 * d;
    e = (d == 0) ? 0 : w / d;
    apb(1'b1, c, 8'h00);
    apb(1'b1, n, 8'h00);
    apb(1'b1, c, code[7:0]);
    repeat (w) @(posedge clk);
    apb(1'b1, c, 8'h00);
    apb(1'b0, n, 8'h00);
    chkr("prescaled count", e - (e > 0), e + (d == 1) * 3 + (e > 0), rv);
  endtask : tdiv

  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    #3000000;
    n_fail++;
    print_verdict();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, ASYNC_STATUS_IDX, 8'h00);
    chk("status reset", 32'h0, rv);
    apb(1'b0, 8'h3f, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, re});
    chk("unmapped data", 32'h0, rv);
    for (int i = 0; i < 6; i++)
      tdiv(T0_CONTROL_IDX, T0_COUNT_IDX, i, d0[i]);
    for (int i = 0; i < 8; i++)
      tdiv(T2_CONTROL_IDX, T2_COUNT_IDX, i, d2[i]);
    for (int j = 0; j < 2; j++)
    begin
      apb(1'b1, T0_CONTROL_IDX, j ? {5'h00, CS_C6} : {5'h00, CS_C7});
      apb(1'b1, T0_COUNT_IDX, 8'h00);
      k = 0;
      repeat (7)
      begin
        if (ext_pin == j[0])
          k++;
        ext_pin <= ~ext_pin;
        repeat (4) @(posedge clk);
      end
      repeat (8) @(posedge clk);
      apb(1'b0, T0_COUNT_IDX, 8'h00);
      chk("pin edge count", k, rv);
    end
    gie <= 1'b1;
    apb(1'b1, MASK_IDX, 8'h02);
    apb(1'b1, T0_COMPARE_IDX, 8'h05);
    apb(1'b1, T0_COUNT_IDX, 8'hf8);
    apb(1'b1, T0_CONTROL_IDX, {5'h00, CS_DIRECT});
    k = 0;
    while (ma0 !== 1'b1 && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    chk("match request", 32'h1, {31'h0, ma0});
    chk("masked overflow", 32'h0, {31'h0, ov0});
    apb(1'b1, T0_CONTROL_IDX, 8'h00);
    apb(1'b0, FLAGS_IDX, 8'h00);
    chk("flags", 32'h3, rv);
    apb(1'b1, FLAGS_IDX, 8'h0f);
    apb(1'b1, T0_COUNT_IDX, 8'h05);
    apb(1'b1, T0_CONTROL_IDX, {5'h00, CS_DIRECT});
    repeat (20) @(posedge clk);
    apb(1'b1, T0_CONTROL_IDX, 8'h00);
    apb(1'b0, FLAGS_IDX, 8'h00);
    chk("flags after count write", 32'h0, rv);
    apb(1'b0, T0_COUNT_IDX, 8'h00);
    chkr("resumed count", 25, 30, rv);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, T0_CONTROL_IDX, 8'h00);
      apb(1'b1, T0_COMPARE_IDX, pc[i]);
      apb(1'b1, T0_CONTROL_IDX, pm[i]);
      repeat (600) @(posedge clk);
      k = 0;
      repeat (1020)
      begin
        @(negedge clk);
        if (out0 === 1'b1)
          k++;
      end
      chkr("pwm high cycles", ph[i] - 8, ph[i] + 8, k);
    end
    repeat (4)
    begin
      b = rnd();
      apb(1'b1, T0_COMPARE_IDX, b);
      apb(1'b0, T0_COMPARE_IDX, 8'h00);
      chk("compare readback", {24'h0, b}, rv);
    end
    apb(1'b1, T2_CONTROL_IDX, 8'h00);
    apb(1'b1, ASYNC_STATUS_IDX, 8'hff);
    apb(1'b0, ASYNC_STATUS_IDX, 8'h00);
    chk("async status", 32'h8, rv);
    b = rnd();
    apb(1'b1, T2_COUNT_IDX, b);
    apb(1'b1, T2_COMPARE_IDX, ~b);
    apb(1'b1, T2_CONTROL_IDX, 8'h20);
    apb(1'b0, ASYNC_STATUS_IDX, 8'h00);
    chk("update busy", 32'hf, rv);
    chk("t2 output not yet on", 32'h0, {31'h0, act2});
    repeat (100) @(posedge clk);
    apb(1'b0, ASYNC_STATUS_IDX, 8'h00);
    chk("busy cleared", 32'h8, rv);
    apb(1'b0, T2_COUNT_IDX, 8'h00);
    chk("landed count", {24'h0, b}, rv);
    apb(1'b0, T2_COMPARE_IDX, 8'h00);
    chk("landed compare", {24'h0, ~b}, rv);
    chk("t2 output on", 32'h1, {31'h0, act2});
    chk("pins claimed", 32'h1, {31'h0, claim});
    apb(1'b1, ASYNC_STATUS_IDX, 8'h00);
    apb(1'b1, MASK_IDX, 8'h00);
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule : test_eight_bit_timer_pwm
